// file: shared/wecr_map.svh
// Register offsets, bit positions, reset values and timing counts
`ifndef WECR_MAP_SVH
`define WECR_MAP_SVH
`define WECR_ADDR_CAUSE 4'h0
`define WECR_ADDR_CTRL 4'h1
`define WECR_ADDR_STAT 4'h2
`define WECR_B_PRIO_EN 7
`define WECR_B_SW_BROWNOUT 6
`define WECR_B_RESET_INSTR 4
`define WECR_B_WDOG_TIMEOUT 3
`define WECR_B_POWERDOWN 2
`define WECR_B_POWER_ON 1
`define WECR_B_BROWNOUT 0
`define WECR_B_IDLE_EN 0
`define WECR_B_CLK_SEL_LO 1
`define WECR_B_FREQ_SEL_LO 4
`define WECR_CAUSE_RST 8'h1c
`define WECR_CTRL_RST 8'h00
`define WECR_CLK_NS 40
`define WECR_START_NS 1000
`define WECR_SETTLE_NS 1000
`define WECR_PLL_LOCK_US 2000
`define WECR_START_CYC ((`WECR_START_NS + `WECR_CLK_NS - 1) / `WECR_CLK_NS)
`define WECR_SETTLE_CYC ((`WECR_SETTLE_NS + `WECR_CLK_NS - 1) / `WECR_CLK_NS)
`define WECR_PLL_LOCK_CYC \
  ((`WECR_PLL_LOCK_US * 1000 + `WECR_CLK_NS - 1) / `WECR_CLK_NS)
`define WECR_OSC_START_CYC 1024
`define WECR_FILT_CYC 3'h4
`endif

// file: shared/wecr_pkg.sv
// Types shared by the wake and reset-cause block
package wecr_pkg;
  typedef enum logic [2:0] {
    ST_RESET = 3'h0, ST_RUN = 3'h1, ST_IDLE = 3'h3,
    ST_SLEEP = 3'h2, ST_WAKE = 3'h6
  } wecr_state_e;
  typedef enum logic [2:0] {
    PM_LOW_POWER_CRYSTAL = 3'h0, PM_STD_CRYSTAL = 3'h1,
    PM_HIGH_SPEED_CRYSTAL = 3'h2, PM_HIGH_SPEED_X4 = 3'h3,
    PM_EXT_CLOCK = 3'h4, PM_RES_CAP = 3'h5, PM_INT_OSC = 3'h6
  } wecr_mode_e;
  typedef enum logic [2:0] {
    CAUSE_POWER_ON = 3'h0, CAUSE_PIN_RUN = 3'h1, CAUSE_PIN_LOWPWR = 3'h2,
    CAUSE_WDOG = 3'h3, CAUSE_BROWNOUT = 3'h4, CAUSE_INSTR = 3'h5,
    CAUSE_STK_FULL = 3'h6, CAUSE_STK_UNDER = 3'h7
  } wecr_cause_e;
  typedef enum logic [1:0] {
    CS_PRIMARY = 2'h0, CS_SECONDARY = 2'h1, CS_INTERNAL = 2'h2
  } wecr_clk_e;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wecr_bus_s;
  typedef struct packed {
    logic pin_reset_en;
    logic [1:0] brownout_config;
    logic two_speed_en;
    logic fail_safe_en;
    wecr_mode_e mode;
  } wecr_cfg_s;
  typedef struct packed {
    logic sleep_instr;
    logic clr_instr;
    logic reset_instr;
    logic stk_full;
    logic stk_under;
    logic wdog_timeout;
    logic clk_fail;
    logic brownout;
  } wecr_evt_s;
endpackage

// file: hw/wecr_top.sv
// Wake-up exit sequencing and reset-cause tracking
`timescale 1ns/1ps
`default_nettype none
`include "wecr_map.svh"
// What this block does
// [R1] Enabled raised interrupt flag starts wake-up
// [R2] Vector after wake only with global enable
// [R3] Fixed start delay, then run next cycle
// [R4] Watchdog wakes when asleep, resets when running
// [R5] Four events clear watchdog and postscaler
// [R6] Reset held until primary ready, flag set
// [R7] Two-speed start runs early on internal osc
// [R8] Skip start-up timer for running or non-crystal
// [R9] Primary-idle wake uses only start delay
// [R10] Crystal wake waits start-up, plus PLL lock
// [R11] Internal osc target runs during settle time
// [R12] Start delay overlaps oscillator delays
// [R13] Eight distinct reset causes recorded
// [R14] Cause flags cleared by events, set by software
// [R15] Priority bit selects two interrupt levels
// [R16] Software brown-out bit acts only when selected
// [R17] Brown-out flag cleared by brown-out reset
// [R18] Software infers brown-out from two flags
// [R19] Power-on flag cleared only by power-on
// [R20] Timeout and powerdown flags track instructions
// [R21] Reset pin low resets, short pulses filtered
// [R22] Reset pin never driven by device
// [R23] Pin disabled becomes plain digital input
module wecr_top #(
  parameter int unsigned PLL_LOCK_CYC = `WECR_PLL_LOCK_CYC
) (
  input wire logic ref_clk, // 25 MHz clock
  input wire logic rst_n, // Power-on reset
  input wire wecr_pkg::wecr_bus_s bus, // Register request
  output logic [7:0] rdata, // Read data, cycle after read
  input wire wecr_pkg::wecr_cfg_s cfg, // Configuration fuses
  input wire wecr_pkg::wecr_evt_s evt, // Core event pulses
  input wire logic [7:0] irq_flag, // Interrupt flags
  input wire logic [7:0] irq_en, // Interrupt enables
  input wire logic global_interrupt_enable, // Vectoring enable
  input wire logic ext_reset_pin_i, // Reset pin level
  output logic ext_reset_pin_o, // Reset pin drive value
  output logic ext_reset_pin_oe_n, // Reset pin enable, low drives
  output logic ext_reset_pin_din, // Reset pin as digital input
  output logic core_reset, // Core held in reset
  output logic cpu_run, // CPU executing
  output logic vector_jump, // Branch to interrupt vector
  output logic wdog_clear, // Clear watchdog and postscaler
  output logic primary_clk_en, // Primary oscillator on
  output logic on_int_osc, // Clocked from internal osc
  output logic brownout_enable, // Brown-out detector on
  output logic prio_two_level // Two interrupt priority levels
);
  localparam int START_MIN = `WECR_START_CYC;
  wecr_pkg::wecr_state_e state_reg, state_next;
  wecr_pkg::wecr_cause_e cause_last_reg;
  logic [7:0] cause_reg, ctrl_reg;
  logic [16:0] osc_cnt_reg;
  logic [4:0] start_cnt_reg, settle_cnt_reg;
  logic [5:0] wake_age_reg;
  logic [2:0] filt_cnt_reg;
  logic boot_reg, pin_s1, pin_s2, wake_vec_reg;
  logic primary_ready_flag, internal_osc_stable_flag;
  logic wake_evt, irq_wake, pin_rst, bor_rst, wdog_rst, int_rst;
  logic rst_start, go_wake, seq_start, pm_entry, sleep_entry;
  logic tgt_primary, crystal, need_osc, int_fast_tgt, need_settle;
  logic fast_start, osc_busy, ctrl_wr, freq_wr;
  wecr_pkg::wecr_clk_e clk_sel;

  assign clk_sel = wecr_pkg::wecr_clk_e'(ctrl_reg[2:1]);
  assign fast_start = cfg.two_speed_en | cfg.fail_safe_en; // [R7]
  assign irq_wake = |(irq_flag & irq_en); // [R1]
  assign wake_evt = irq_wake | evt.wdog_timeout; // [R4]
  assign pin_rst = filt_cnt_reg == `WECR_FILT_CYC; // [R21]
  assign bor_rst = evt.brownout & brownout_enable;
  assign wdog_rst = evt.wdog_timeout && state_reg == wecr_pkg::ST_RUN; // [R4]
  assign int_rst = pin_rst | bor_rst | wdog_rst | evt.reset_instr
                 | evt.stk_full | evt.stk_under;
  assign rst_start = !boot_reg | int_rst;
  assign go_wake = (state_reg == wecr_pkg::ST_IDLE
                 || state_reg == wecr_pkg::ST_SLEEP) && wake_evt && !int_rst;
  assign seq_start = go_wake | rst_start;
  assign pm_entry = state_reg == wecr_pkg::ST_RUN && evt.sleep_instr
                  && !int_rst;
  assign sleep_entry = pm_entry && !ctrl_reg[`WECR_B_IDLE_EN];
  assign tgt_primary = rst_start || clk_sel == wecr_pkg::CS_PRIMARY;
  assign crystal = cfg.mode <= wecr_pkg::PM_HIGH_SPEED_X4;
  // Primary idle keeps the crystal running, so no start-up wait
  assign need_osc = tgt_primary && crystal && !(go_wake && primary_clk_en
                  && state_reg == wecr_pkg::ST_IDLE); // [R8] [R9]
  assign int_fast_tgt = (tgt_primary && cfg.mode == wecr_pkg::PM_INT_OSC)
                      || (!rst_start && clk_sel == wecr_pkg::CS_INTERNAL
                          && ctrl_reg[6:4] != 3'h0); // [R11]
  assign need_settle = int_fast_tgt
                     && (rst_start || !internal_osc_stable_flag); // [R11]
  assign osc_busy = osc_cnt_reg != 17'h0;
  assign ctrl_wr = bus.wr && bus.addr == `WECR_ADDR_CTRL;
  assign freq_wr = ctrl_wr && bus.wdata[6:4] != ctrl_reg[6:4];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      ext_reset_pin_din <= 1'b1;
      filt_cnt_reg <= 3'h0;
    end else begin
      pin_s1 <= ext_reset_pin_i;
      pin_s2 <= pin_s1;
      ext_reset_pin_din <= pin_s2; // [R23]
      if (!cfg.pin_reset_en || pin_s2) begin // [R23]
        filt_cnt_reg <= 3'h0;
      end else if (!pin_rst) begin // [R21]
        filt_cnt_reg <= filt_cnt_reg + 3'h1;
      end
    end
  end

  // Pin is input only; the drive enable never asserts
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_reset_pin_o <= 1'b0;
      ext_reset_pin_oe_n <= 1'b1; // [R22]
    end else begin
      ext_reset_pin_o <= 1'b0;
      ext_reset_pin_oe_n <= 1'b1; // [R22]
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      wecr_pkg::ST_RESET: begin
        if (boot_reg && (fast_start || !osc_busy)) begin // [R6] [R7]
          state_next = wecr_pkg::ST_RUN;
        end
      end
      wecr_pkg::ST_RUN: begin
        if (evt.sleep_instr) begin
          state_next = ctrl_reg[`WECR_B_IDLE_EN] ? wecr_pkg::ST_IDLE
                                                 : wecr_pkg::ST_SLEEP;
        end
      end
      wecr_pkg::ST_IDLE, wecr_pkg::ST_SLEEP: begin
        if (wake_evt) begin // [R1] [R4]
          state_next = wecr_pkg::ST_WAKE;
        end
      end
      wecr_pkg::ST_WAKE: begin
        // Crystal wake stays unclocked until ready unless two-speed or fail-safe is enabled
        if (start_cnt_reg == 5'h0 && (fast_start || !osc_busy)) begin
          state_next = wecr_pkg::ST_RUN; // [R3] [R10] [R12]
        end
      end
      default: state_next = wecr_pkg::ST_RESET;
    endcase
    if (int_rst) begin
      state_next = wecr_pkg::ST_RESET;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= wecr_pkg::ST_RESET;
      boot_reg <= 1'b0;
      core_reset <= 1'b1;
      cpu_run <= 1'b0;
    end else begin
      state_reg <= state_next;
      boot_reg <= 1'b1;
      core_reset <= state_next == wecr_pkg::ST_RESET; // [R6]
      cpu_run <= state_next == wecr_pkg::ST_RUN; // [R3]
    end
  end

  // Start delay and oscillator waits load together and run in parallel
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_cnt_reg <= 5'h0;
      osc_cnt_reg <= 17'h0;
      settle_cnt_reg <= 5'h0;
      wake_age_reg <= 6'h0;
    end else begin
      if (go_wake) begin
        start_cnt_reg <= 5'(`WECR_START_CYC); // [R3] [R12]
      end else if (start_cnt_reg != 5'h0) begin
        start_cnt_reg <= start_cnt_reg - 5'h1;
      end
      if (seq_start) begin
        osc_cnt_reg <= !need_osc ? 17'h0 : 17'(`WECR_OSC_START_CYC)
                     + (cfg.mode == wecr_pkg::PM_HIGH_SPEED_X4
                        ? 17'(PLL_LOCK_CYC) : 17'h0); // [R8] [R10]
      end else if (pm_entry && !primary_ready_flag) begin
        osc_cnt_reg <= 17'h0; // [R7]
      end else if (osc_busy) begin
        osc_cnt_reg <= osc_cnt_reg - 17'h1;
      end
      if (seq_start) begin
        settle_cnt_reg <= need_settle ? 5'(`WECR_SETTLE_CYC) : 5'h0;
      end else if (settle_cnt_reg != 5'h0) begin
        settle_cnt_reg <= settle_cnt_reg - 5'h1; // [R11]
      end
      if (state_reg != wecr_pkg::ST_WAKE) begin
        wake_age_reg <= 6'h0;
      end else if (wake_age_reg != 6'h3f) begin
        wake_age_reg <= wake_age_reg + 6'h1;
      end
    end
  end

  // Setting a ready flag wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      primary_ready_flag <= 1'b0;
      internal_osc_stable_flag <= 1'b0;
    end else begin
      if (rst_start || sleep_entry) begin
        primary_ready_flag <= 1'b0;
        internal_osc_stable_flag <= 1'b0;
      end
      if (osc_cnt_reg == 17'h1 || (seq_start && tgt_primary && !crystal
          && cfg.mode != wecr_pkg::PM_INT_OSC)) begin
        primary_ready_flag <= 1'b1; // [R6] [R9] [R10]
      end
      if (settle_cnt_reg == 5'h1) begin
        internal_osc_stable_flag <= 1'b1; // [R6] [R11]
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      primary_clk_en <= 1'b0;
      on_int_osc <= 1'b0;
    end else begin
      primary_clk_en <= tgt_primary && state_next != wecr_pkg::ST_SLEEP
                     && !(state_next == wecr_pkg::ST_IDLE
                          && !primary_ready_flag); // [R7]
      on_int_osc <= int_fast_tgt || (!rst_start
                    && clk_sel == wecr_pkg::CS_INTERNAL)
                    || (fast_start && crystal && tgt_primary
                        && !primary_ready_flag); // [R7]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_vec_reg <= 1'b0;
      vector_jump <= 1'b0;
      wdog_clear <= 1'b0;
    end else begin
      if (go_wake) begin
        wake_vec_reg <= irq_wake && global_interrupt_enable; // [R2]
      end
      vector_jump <= state_reg == wecr_pkg::ST_WAKE
                  && state_next == wecr_pkg::ST_RUN && wake_vec_reg; // [R2]
      wdog_clear <= pm_entry || evt.clr_instr
                 || (evt.clk_fail && cfg.fail_safe_en)
                 || (freq_wr && on_int_osc); // [R5]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_last_reg <= wecr_pkg::CAUSE_POWER_ON; // [R13]
    end else if (pin_rst) begin
      // Pin held through reset must not relabel a low-power pin reset
      if (state_reg != wecr_pkg::ST_RUN
          && state_reg != wecr_pkg::ST_RESET) begin
        cause_last_reg <= wecr_pkg::CAUSE_PIN_LOWPWR; // [R13]
      end else if (state_reg == wecr_pkg::ST_RUN
                   || cause_last_reg != wecr_pkg::CAUSE_PIN_LOWPWR) begin
        cause_last_reg <= wecr_pkg::CAUSE_PIN_RUN; // [R13]
      end
    end else if (wdog_rst) begin
      cause_last_reg <= wecr_pkg::CAUSE_WDOG;
    end else if (bor_rst) begin
      cause_last_reg <= wecr_pkg::CAUSE_BROWNOUT;
    end else if (evt.reset_instr) begin
      cause_last_reg <= wecr_pkg::CAUSE_INSTR;
    end else if (evt.stk_full) begin
      cause_last_reg <= wecr_pkg::CAUSE_STK_FULL;
    end else if (evt.stk_under) begin
      cause_last_reg <= wecr_pkg::CAUSE_STK_UNDER;
    end
  end

  // Hardware clears follow software sets, so a same-cycle event wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_reg <= `WECR_CAUSE_RST; // [R19] [R20]
    end else begin
      if (bus.wr && bus.addr == `WECR_ADDR_CAUSE) begin
        cause_reg[7:6] <= bus.wdata[7:6]; // [R15] [R16]
        cause_reg[`WECR_B_RESET_INSTR] <= cause_reg[`WECR_B_RESET_INSTR]
                                        | bus.wdata[`WECR_B_RESET_INSTR];
        cause_reg[`WECR_B_POWER_ON] <= cause_reg[`WECR_B_POWER_ON]
                                     | bus.wdata[`WECR_B_POWER_ON]; // [R19]
        cause_reg[`WECR_B_BROWNOUT] <= cause_reg[`WECR_B_BROWNOUT]
                                     | bus.wdata[`WECR_B_BROWNOUT]; // [R14]
      end
      if (!boot_reg) begin
        cause_reg[`WECR_B_SW_BROWNOUT] <= cfg.brownout_config == 2'h1;
      end
      if (evt.reset_instr) begin
        cause_reg[`WECR_B_RESET_INSTR] <= 1'b0; // [R14]
      end
      if (bor_rst) begin
        cause_reg[`WECR_B_BROWNOUT] <= 1'b0; // [R17]
      end
      if (evt.clr_instr) begin
        cause_reg[`WECR_B_WDOG_TIMEOUT] <= 1'b1; // [R20]
        cause_reg[`WECR_B_POWERDOWN] <= 1'b1;
      end
      if (pm_entry) begin
        cause_reg[`WECR_B_WDOG_TIMEOUT] <= 1'b1; // [R20]
        cause_reg[`WECR_B_POWERDOWN] <= 1'b0;
      end
      if (evt.wdog_timeout) begin
        cause_reg[`WECR_B_WDOG_TIMEOUT] <= 1'b0; // [R20]
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `WECR_CTRL_RST;
    end else if (int_rst) begin
      ctrl_reg[3:1] <= 3'h0;
    end else if (ctrl_wr) begin
      ctrl_reg <= {1'b0, bus.wdata[6:0]};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      brownout_enable <= 1'b0;
      prio_two_level <= 1'b0;
    end else begin
      case (cfg.brownout_config)
        2'h0: brownout_enable <= 1'b0;
        2'h1: brownout_enable <= cause_reg[`WECR_B_SW_BROWNOUT]; // [R16]
        2'h2: brownout_enable <= state_next != wecr_pkg::ST_SLEEP;
        default: brownout_enable <= 1'b1;
      endcase
      prio_two_level <= cause_reg[`WECR_B_PRIO_EN]; // [R15]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (!bus.rd) begin
      rdata <= 8'h00;
    end else begin
      case (bus.addr)
        `WECR_ADDR_CAUSE: rdata <= {cause_reg[7],
          cause_reg[6] & (cfg.brownout_config == 2'h1), 1'b0,
          cause_reg[4:0]}; // [R14] [R16]
        `WECR_ADDR_CTRL: rdata <= ctrl_reg;
        `WECR_ADDR_STAT: rdata <= {internal_osc_stable_flag,
          primary_ready_flag, cause_last_reg, state_reg};
        default: rdata <= 8'h00;
      endcase
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_wake_irq: assert property ( // [R1]
    state_reg == wecr_pkg::ST_SLEEP && irq_wake && !int_rst
    |=> state_reg == wecr_pkg::ST_WAKE)
    else $error("enabled interrupt did not wake");
  chk_vector_gie: assert property ( // [R2]
    vector_jump |-> cpu_run && $past(wake_vec_reg))
    else $error("vector taken without global enable");
  chk_start_delay: assert property ( // [R3]
    $rose(cpu_run) && $past(state_reg) == wecr_pkg::ST_WAKE
    |-> $past(wake_age_reg) >= 6'(START_MIN))
    else $error("execution before start delay");
  chk_wdog_run: assert property ( // [R4]
    state_reg == wecr_pkg::ST_RUN && evt.wdog_timeout
    |=> core_reset && cause_last_reg == wecr_pkg::CAUSE_WDOG)
    else $error("watchdog in run did not reset");
  chk_wdog_wake: assert property ( // [R4]
    (state_reg == wecr_pkg::ST_SLEEP || state_reg == wecr_pkg::ST_IDLE)
    && evt.wdog_timeout && !int_rst
    |=> state_reg == wecr_pkg::ST_WAKE && !core_reset)
    else $error("watchdog in sleep did not wake");
  chk_wdog_clear: assert property ( // [R5]
    evt.clr_instr |=> wdog_clear)
    else $error("watchdog not cleared");
  chk_pin_filter: assert property ( // [R21]
    pin_rst |-> !$past(pin_s2, 1) && !$past(pin_s2, 2)
    && !$past(pin_s2, 3) && cfg.pin_reset_en)
    else $error("short pin pulse reset the device");
  chk_pin_undriven: assert property ( // [R22]
    ext_reset_pin_oe_n)
    else $error("reset pin driven");
  chk_brownout_flag: assert property ( // [R17]
    bor_rst |=> !cause_reg[`WECR_B_BROWNOUT] && core_reset)
    else $error("brown-out flag not cleared");
  chk_sleep_flags: assert property ( // [R20]
    pm_entry && !evt.wdog_timeout |=> !cause_reg[`WECR_B_POWERDOWN]
    && cause_reg[`WECR_B_WDOG_TIMEOUT])
    else $error("sleep flags wrong");

  cov_irq_vector: cover property (go_wake ##[1:60] vector_jump);
  cov_wdog_reset: cover property (wdog_rst ##1 core_reset);
  cov_pin_reset: cover property (pin_rst ##1 core_reset);
  cov_primary_ready: cover property ($rose(primary_ready_flag));
endmodule // wecr_top
`default_nettype wire

// file: dv/wecr_pin_drv.sv
// Reset pin driver model with a pull-up on the line
`timescale 1ns/1ps
`default_nettype none
module wecr_pin_drv (
  input wire logic ref_clk, // Bench clock
  input wire logic go, // Start one low pulse
  input wire logic [4:0] len, // Low time in cycles
  output logic pin // Reset pin level
);
  logic [4:0] low_reg;
  initial low_reg = 5'h00;
  always @(posedge ref_clk) begin
    if (go)
      low_reg <= len;
    else if (low_reg != 5'h00)
      low_reg <= low_reg - 5'h01;
  end
  // Released line floats back to the pull-up level
  assign pin = (low_reg == 5'h00);
endmodule // wecr_pin_drv
`default_nettype wire

// file: dv/wecr_tb_top.sv
// Self-checking bench for the wake and reset-cause block
`timescale 1ns/1ps
`default_nettype none
`include "wecr_map.svh"
module wecr_tb_top;
  typedef struct {string n; logic [7:0] e; logic [7:0] m;} wecr_note_s;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  wecr_pkg::wecr_bus_s bus;
  wecr_pkg::wecr_cfg_s cfg;
  wecr_pkg::wecr_evt_s evt;
  logic [7:0] rdata, irq_flag, irq_en, r;
  logic gie, pin, pin_go, pin_o, pin_oe_n, din, core_reset, cpu_run, vj;
  logic wdog_clear, prio, bo_en, rd_seen, rst_seen, f, pce, ioo;
  localparam int PLL_CYC = 8;
  logic [4:0] pin_len;
  int bad_count = 0;
  int compares = 0;
  int seed = 90;
  int n;
  int eb[5] = '{5, 4, 3, 2, 0};
  logic [7:0] em[5] = '{8'h10, 8'h00, 8'h00, 8'h08, 8'h01};
  wecr_pkg::wecr_cause_e ec[5] = '{wecr_pkg::CAUSE_INSTR,
    wecr_pkg::CAUSE_STK_FULL, wecr_pkg::CAUSE_STK_UNDER,
    wecr_pkg::CAUSE_WDOG, wecr_pkg::CAUSE_BROWNOUT};
  wecr_note_s q[$];

  wecr_top #(.PLL_LOCK_CYC(PLL_CYC)) i_wecr_top (.ref_clk(ref_clk),
    .rst_n(rst_n), .bus(bus), .rdata(rdata), .cfg(cfg), .evt(evt),
    .irq_flag(irq_flag), .irq_en(irq_en), .global_interrupt_enable(gie),
    .ext_reset_pin_i(pin), .ext_reset_pin_o(pin_o),
    .ext_reset_pin_oe_n(pin_oe_n), .ext_reset_pin_din(din),
    .core_reset(core_reset), .cpu_run(cpu_run), .vector_jump(vj),
    .wdog_clear(wdog_clear), .primary_clk_en(pce), .on_int_osc(ioo),
    .brownout_enable(bo_en), .prio_two_level(prio));
  wecr_pin_drv i_wecr_pin_drv (.ref_clk(ref_clk), .go(pin_go),
    .len(pin_len), .pin(pin));

  always #20 ref_clk = ~ref_clk;

  task chk(string nm, logic [7:0] s, logic [7:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rd_seen) begin
      chk(q[0].n, rdata & q[0].m, q[0].e);
      void'(q.pop_front());
    end
    rd_seen <= bus.rd;
    if (core_reset === 1'b1)
      rst_seen <= 1'b1;
  end

  task test_done;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task wr(logic [3:0] a, logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    bus <= '0;
  endtask

  task rd(string nm, logic [3:0] a, logic [7:0] m, logic [7:0] e);
    @(posedge ref_clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    q.push_back('{nm, e & m, m});
    @(posedge ref_clk);
    bus <= '0;
  endtask

  task ev(int b);
    @(posedge ref_clk);
    evt <= wecr_pkg::wecr_evt_s'(8'h01 << b);
    @(posedge ref_clk);
    evt <= '0;
  endtask

  task pg(logic [4:0] l);
    @(posedge ref_clk);
    pin_go <= 1'b1;
    pin_len <= l;
    @(posedge ref_clk);
    pin_go <= 1'b0;
  endtask

  function logic sg(int k);
    case (k)
      0: sg = core_reset;
      1: sg = cpu_run;
      2: sg = wdog_clear;
      default: sg = din;
    endcase
  endfunction

  // Every wait is bounded so a hung sequencer ends the run
  task wt(int k, logic v, int lim);
    #1;
    n = 0;
    while (sg(k) !== v) begin
      if (n == lim) begin
        bad_count++;
        $display("wrong value wait %0d expected %b seen timeout", k, v);
        test_done;
      end
      n++;
      @(posedge ref_clk);
      #1;
    end
  endtask

  initial begin
    bus = '0;
    evt = '0;
    irq_flag = 8'h00;
    irq_en = 8'h00;
    gie = 1'b0;
    pin_go = 1'b0;
    pin_len = 5'h00;
    rd_seen = 1'b0;
    rst_seen = 1'b0;
    cfg = '{1'b1, 2'b01, 1'b0, 1'b1, wecr_pkg::PM_EXT_CLOCK};
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    wt(1, 1'b1, 40);
    chk("pin_drive", {6'h00, pin_oe_n, pin_o}, 8'h02);
    rd("cause_por", `WECR_ADDR_CAUSE, 8'hff, 8'h5c);
    rd("stat_por", `WECR_ADDR_STAT, 8'hf8, 8'h40);
    chk("clk_src", {6'h00, pce, ioo}, 8'h02);
    wr(4'hf, 8'($random(seed)));
    rd("unmapped", 4'hf, 8'hff, 8'h00);
    wr(`WECR_ADDR_CAUSE, 8'h93);
    rd("cause_set", `WECR_ADDR_CAUSE, 8'hff, 8'h9f);
    chk("prio", {7'h00, prio}, 8'h01);
    chk("bo_off", {7'h00, bo_en}, 8'h00);
    wr(`WECR_ADDR_CAUSE, 8'hd3);
    @(posedge ref_clk);
    #1;
    chk("bo_on", {7'h00, bo_en}, 8'h01);
    ev(6);
    wt(2, 1'b1, 4);
    for (int k = 0; k < 2; k++) begin
      wr(`WECR_ADDR_CTRL, {7'h00, k[0]});
      r = 8'($random(seed)) | 8'h01;
      irq_en <= r;
      irq_flag <= ~r;
      gie <= ~k[0];
      ev(7);
      wt(2, 1'b1, 4);
      f = 1'b0;
      repeat (40) begin
        @(posedge ref_clk);
        #1;
        f = f | cpu_run;
      end
      chk("no_wake", {7'h00, f}, 8'h00);
      @(posedge ref_clk);
      irq_flag <= r;
      wt(1, 1'b1, 60);
      chk("wake_delay", {7'h00, n >= `WECR_START_CYC &&
        n <= `WECR_START_CYC + 4}, 8'h01);
      chk("vector", {7'h00, vj}, {7'h00, ~k[0]});
      irq_flag <= 8'h00;
      rd("sleep_flags", `WECR_ADDR_CAUSE, 8'h0c, 8'h08);
    end
    // Watchdog time-out while in idle only wakes
    rst_seen = 1'b0;
    ev(7);
    ev(2);
    wt(1, 1'b1, 60);
    chk("wdog_wake", {7'h00, rst_seen}, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(`WECR_ADDR_CAUSE, 8'hd3);
      // Clear instruction first, so the time-out flag starts high
      ev(6);
      ev(eb[i]);
      wt(0, 1'b1, 8);
      wt(0, 1'b0, 40);
      wt(1, 1'b1, 40);
      rd("cause_flags", `WECR_ADDR_CAUSE, em[i] | 8'h02, 8'h02);
      rd("last_cause", `WECR_ADDR_STAT, 8'h38, {2'b00, ec[i], 3'b000});
    end
    for (int k = 0; k < 2; k++) begin
      if (k == 1)
        ev(7);
      rst_seen = 1'b0;
      pg(5'h02);
      repeat (15) @(posedge ref_clk);
      chk("short_pulse", {7'h00, rst_seen}, 8'h00);
      pg(5'h0c);
      wt(0, 1'b1, 20);
      chk("pin_drive", {6'h00, pin_oe_n, pin_o}, 8'h02);
      wt(0, 1'b0, 40);
      wt(1, 1'b1, 40);
      rd("pin_cause", `WECR_ADDR_STAT, 8'h38, (k == 0) ?
        {2'b00, wecr_pkg::CAUSE_PIN_RUN, 3'b000} :
        {2'b00, wecr_pkg::CAUSE_PIN_LOWPWR, 3'b000});
    end
    // Pin disabled: plain input, never a reset
    cfg.pin_reset_en <= 1'b0;
    rst_seen = 1'b0;
    pg(5'h0c);
    wt(3, 1'b0, 8);
    repeat (20) @(posedge ref_clk);
    chk("pin_off", {7'h00, rst_seen}, 8'h00);
    // Crystal with PLL and no fast start: held for start-up and lock
    cfg <= '{1'b1, 2'b01, 1'b0, 1'b0, wecr_pkg::PM_HIGH_SPEED_X4};
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    wt(1, 1'b1, 1100);
    chk("osc_wait", {7'h00, n >= `WECR_OSC_START_CYC + PLL_CYC}, 8'h01);
    chk("clk_xtal", {6'h00, pce, ioo}, 8'h02);
    rd("osc_ready", `WECR_ADDR_STAT, 8'hf8, 8'h40);
    @(posedge ref_clk);
    #1;
    test_done;
  end
endmodule // wecr_tb_top
`default_nettype wire
